// file: src/aics_top.sv
// control register, conversion sequencing and input selection
// assumes a synchronous sample_start_n and a raw code from the analog core
`timescale 1ns/1ps
`default_nettype none
module aics_top
  import aics_pkg::*;
#(
  parameter int RES_W    = aics_pkg::RES_W,
  parameter int CONV_CYC = aics_pkg::CONV_CYC
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  input  wire logic [aics_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [aics_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [aics_pkg::DATA_W-1:0] rd_data_o,
  input  wire logic                    sample_start_n_i,
  input  wire logic [RES_W-1:0]        raw_code_i,
  output aics_pkg::aics_mux_t          mux_sel_o,
  output logic                         span_double_o,
  output logic                         busy_o,
  output logic                         manual_o,
  output logic      [RES_W-1:0]        result_o,
  output logic                         result_valid_o
);
  import aics_pkg::*;

  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);

  aics_ctrl_t             ctrl_q,   ctrl_d;
  aics_ctrl_t             active_q, active_d;
  aics_state_t            state_q,  state_d;
  logic [CNT_W-1:0]       cnt_q,    cnt_d;
  logic                   start_n_q;
  logic                   start_evt;
  logic                   conv_done;
  aics_mux_t              sel_q,    sel_d;
  aics_mux_t              sel_idle, sel_act;
  logic                   span_q,   span_d;
  logic                   manual_q, manual_d;
  logic [RES_W-1:0]       result_q, result_d;
  logic                   valid_q,  valid_d;
  logic                   busy_q,   busy_d;
  logic [RES_W-1:0]       coded;
  logic [DATA_W-1:0]      rdata_q,  rdata_d;
  logic                   ctrl_wr;

  // decode for the selection that tracks the register while idle
  aics_mux_sel u_sel_idle (
    .ctrl_i (ctrl_q),
    .sel_o  (sel_idle)
  );

  // decode for the snapshot taken at conversion start
  aics_mux_sel u_sel_act (
    .ctrl_i (active_d),
    .sel_o  (sel_act)
  );

  aics_coder #(
    .RES_W (RES_W)
  ) u_coder (
    .raw_i  (raw_code_i),
    .twos_i (active_q.fmt_twos),
    .code_o (coded)
  );

  // falling edge of the start input, pin already synchronous
  always_comb begin
    start_evt = start_n_q && !sample_start_n_i;
    conv_done = (state_q == AICS_CONV) && (cnt_q == CONV_LAST);
    ctrl_wr   = wr_i && (addr_i == OFS_CTRL);
  end

  // control register: only a write changes the channel
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = aics_ctrl_t'(wr_data_i[CTRL_W-1:0]);
    end
  end

  // conversion sequencing; a start during a conversion is ignored
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    active_d = active_q;
    case (state_q)
      AICS_IDLE: begin
        cnt_d = '0;
        if (start_evt) begin
          // snapshot the settled register, not one being written now
          active_d = ctrl_q;
          state_d  = AICS_CONV;
        end
      end
      AICS_CONV: begin
        cnt_d = cnt_q + CNT_W'(1);
        if (conv_done) begin
          state_d = AICS_IDLE;
          cnt_d   = '0;
        end
      end
      default: begin
        state_d = AICS_IDLE;
        cnt_d   = '0;
      end
    endcase
  end

  // outputs: mux follows the register in acquisition, frozen in conversion
  always_comb begin
    sel_d    = (state_d == AICS_CONV) ? sel_act : sel_idle;
    span_d   = (state_d == AICS_CONV) ? active_d.span_double
                                      : ctrl_q.span_double;
    manual_d = !ctrl_q.autoscan_ctrl_a && !ctrl_q.autoscan_ctrl_b;
    // own flop so the pin does not hang off a compare
    busy_d   = (state_d == AICS_CONV);
    result_d = result_q;
    valid_d  = 1'b0;
    if (conv_done) begin
      result_d = coded;
      valid_d  = 1'b1;
    end
  end

  // read data stand only in the cycle after the read strobe
  always_comb begin
    rdata_d = '0;
    if (rd_i) begin
      case (addr_i)
        OFS_CTRL: begin
          rdata_d[CTRL_W-1:0] = ctrl_q;
        end
        OFS_STATUS: begin
          rdata_d[F_BUSY]   = (state_q == AICS_CONV);
          rdata_d[F_MANUAL] = manual_q;
          rdata_d[F_ACT_LO +: CTRL_W] = active_q;
        end
        OFS_RESULT: begin
          rdata_d[RES_W-1:0] = result_q;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  // single register stage; clock enable low freezes everything
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q    <= aics_ctrl_t'(CTRL_RST);
      active_q  <= aics_ctrl_t'(CTRL_RST);
      state_q   <= AICS_IDLE;
      cnt_q     <= '0;
      start_n_q <= 1'b1;
      sel_q     <= '0;
      span_q    <= 1'b0;
      manual_q  <= 1'b1;
      result_q  <= '0;
      valid_q   <= 1'b0;
      busy_q    <= 1'b0;
      rdata_q   <= '0;
    end else if (ce_i) begin
      ctrl_q    <= ctrl_d;
      active_q  <= active_d;
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      start_n_q <= sample_start_n_i;
      sel_q     <= sel_d;
      span_q    <= span_d;
      manual_q  <= manual_d;
      result_q  <= result_d;
      valid_q   <= valid_d;
      busy_q    <= busy_d;
      rdata_q   <= rdata_d;
    end
  end

  always_comb begin
    rd_data_o      = rdata_q;
    mux_sel_o      = sel_q;
    span_double_o  = span_q;
    busy_o         = busy_q;
    manual_o       = manual_q;
    result_o       = result_q;
    result_valid_o = valid_q;
  end

  // the outputs above come straight from flops: state_q is a register

  // -------- checks --------
  a_start_snap: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && state_q == AICS_IDLE && start_evt)
      |=> (state_q == AICS_CONV) && (active_q == $past(ctrl_q)))
    else $error("conversion start did not snapshot control");

  a_hold_during: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (state_q == AICS_CONV && !conv_done)
      |=> active_q == $past(active_q))
    else $error("active selection changed during conversion");

  a_sel_frozen: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (state_q == AICS_CONV && $past(state_q) == AICS_CONV && ce_i
      && !conv_done && ctrl_wr)
      |=> mux_sel_o == $past(mux_sel_o))
    else $error("write moved the mux during conversion");

  a_diff_map: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (busy_o && $past(busy_o) && active_q.input_config_hi
      && !active_q.input_config_lo)
      |-> mux_sel_o.fully_diff && !mux_sel_o.neg_gnd
          && mux_sel_o.neg == (mux_sel_o.pos ^ 3'h1)
          && mux_sel_o.pos == active_q.chan_pick_field)
    else $error("differential pair mapping wrong");

  a_pseudo_pair: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (busy_o && $past(busy_o) && !active_q.input_config_hi
      && active_q.input_config_lo)
      |-> !mux_sel_o.fully_diff && !mux_sel_o.neg_gnd
          && mux_sel_o.neg == (mux_sel_o.pos ^ 3'h1))
    else $error("pseudo pair mapping wrong");

  a_common_ref: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (busy_o && $past(busy_o) && active_q.input_config_hi
      && active_q.input_config_lo)
      |-> mux_sel_o.neg == COMMON_REF && !mux_sel_o.neg_gnd)
    else $error("seven-input mode lost the common negative");

  a_single_gnd: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (busy_o && $past(busy_o) && !active_q.input_config_hi
      && !active_q.input_config_lo)
      |-> mux_sel_o.neg_gnd && !mux_sel_o.fully_diff)
    else $error("single-ended input not tied to ground");

  a_result_code: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && conv_done)
      |=> result_valid_o && result_o[RES_W-2:0] == $past(raw_code_i[RES_W-2:0])
          && result_o[RES_W-1] ==
             ($past(raw_code_i[RES_W-1]) ^ $past(active_q.fmt_twos)))
    else $error("result coding wrong");

  a_span_sel: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (busy_o && $past(busy_o)) |-> span_double_o == active_q.span_double)
    else $error("span select does not follow the snapshot");

  a_manual_flag: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && ctrl_wr) ##1 ce_i
      |=> manual_o == ($past(ctrl_q.autoscan_ctrl_a) == 1'b0
                       && $past(ctrl_q.autoscan_ctrl_b) == 1'b0))
    else $error("manual flag does not follow autoscan bits");

  a_start_busy: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && state_q == AICS_IDLE && start_evt)
      |=> busy_o && cnt_q == '0)
    else $error("conversion start did not raise busy");

  a_start_refused: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && state_q == AICS_CONV && !conv_done && start_evt)
      |=> busy_o && active_q == $past(active_q))
    else $error("start during conversion was not ignored");

  a_ctrl_write: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && ctrl_wr) |=> ctrl_q == $past(wr_data_i[CTRL_W-1:0]))
    else $error("control write did not land");

  a_ctrl_keep: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !(ce_i && ctrl_wr) |=> ctrl_q == $past(ctrl_q))
    else $error("control changed without a write");

  a_idle_track: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && state_q == AICS_IDLE && !start_evt)
      |=> mux_sel_o.pos == $past(ctrl_q.chan_pick_field))
    else $error("idle mux does not follow the channel field");

  a_span_idle: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && state_q == AICS_IDLE && !start_evt)
      |=> span_double_o == $past(ctrl_q.span_double))
    else $error("idle span select does not follow control");

  a_full_span: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && conv_done && !active_q.fmt_twos)
      |=> result_o == $past(raw_code_i))
    else $error("straight binary result not full span");

  a_result_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && !conv_done)
      |=> !result_valid_o && result_o == $past(result_o))
    else $error("result changed outside a conversion end");

endmodule
`default_nettype wire

// file: src/aics_pkg.sv
// constants, field layouts and carrier types of the input-config block
// assumes one 250 mhz clock and a plain strobe-style register port
package aics_pkg;

  // register port
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_RESULT  = 8'h08;

  // control field positions
  localparam int          F_CHAN_LO   = 0;
  localparam int          F_CFG_LO    = 3;
  localparam int          F_CFG_HI    = 4;
  localparam int          F_SCAN_A    = 5;
  localparam int          F_SCAN_B    = 6;
  localparam int          F_SPAN      = 7;
  localparam int          F_TWOS      = 8;
  localparam int          CTRL_W      = 9;
  localparam logic [8:0]  CTRL_RST    = 9'h000;

  // status field positions
  localparam int          F_BUSY      = 0;
  localparam int          F_MANUAL    = 1;
  localparam int          F_ACT_LO    = 4;

  // converter resolution and conversion time
  localparam int          RES_W       = 12;
  localparam int          CLK_MHZ     = 250;
  localparam int          CONV_NS     = 800;
  localparam int          CONV_CYC    = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W       = 8;

  // input arrangement codes, {hi, lo}
  localparam logic [1:0]  CFG_SINGLE  = 2'h0;
  localparam logic [1:0]  CFG_PSEUDO4 = 2'h1;
  localparam logic [1:0]  CFG_DIFF    = 2'h2;
  localparam logic [1:0]  CFG_PSEUDO7 = 2'h3;
  localparam logic [2:0]  COMMON_REF  = 3'h7;

  typedef struct packed {
    logic       fmt_twos;
    logic       span_double;
    logic       autoscan_ctrl_b;
    logic       autoscan_ctrl_a;
    logic       input_config_hi;
    logic       input_config_lo;
    logic [2:0] chan_pick_field;
  } aics_ctrl_t;

  typedef struct packed {
    logic [2:0] pos;       // multiplexer input on the positive side
    logic [2:0] neg;       // multiplexer input on the negative side
    logic       neg_gnd;   // negative side tied to analog ground
    logic       fully_diff;
  } aics_mux_t;

  typedef enum logic [0:0] {
    AICS_IDLE,
    AICS_CONV
  } aics_state_t;

endpackage

// file: src/aics_mux_sel.sv
// input multiplexer decode from arrangement and channel field
// assumes the caller registers the result before it reaches pins
`timescale 1ns/1ps
`default_nettype none
module aics_mux_sel
  import aics_pkg::*;
(
  input  wire aics_pkg::aics_ctrl_t ctrl_i,
  output aics_pkg::aics_mux_t       sel_o
);
  logic [1:0] cfg;

  // pair modes use the neighbour of the picked input as the negative
  always_comb begin
    cfg            = {ctrl_i.input_config_hi, ctrl_i.input_config_lo};
    sel_o.pos      = ctrl_i.chan_pick_field;
    sel_o.neg      = ctrl_i.chan_pick_field ^ 3'h1;
    sel_o.neg_gnd  = 1'b0;
    sel_o.fully_diff = 1'b0;
    case (cfg)
      CFG_SINGLE: begin
        sel_o.neg     = ctrl_i.chan_pick_field;
        sel_o.neg_gnd = 1'b1;
      end
      CFG_DIFF: begin
        sel_o.fully_diff = 1'b1;
      end
      CFG_PSEUDO4: begin
        sel_o.fully_diff = 1'b0;
      end
      CFG_PSEUDO7: begin
        sel_o.neg = COMMON_REF;
      end
      default: begin
        sel_o.neg_gnd = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

// file: src/aics_coder.sv
// output coding of a raw successive-approximation code
// assumes the raw code is straight binary, zero at the negative limit
`timescale 1ns/1ps
`default_nettype none
module aics_coder #(
  parameter int RES_W = 12
) (
  input  wire logic [RES_W-1:0] raw_i,
  input  wire logic             twos_i,
  output logic      [RES_W-1:0] code_o
);
  // twos complement is straight binary with the top bit inverted
  always_comb begin
    code_o = raw_i;
    if (twos_i) begin
      code_o[RES_W-1] = ~raw_i[RES_W-1];
    end
  end
endmodule
`default_nettype wire

// file: testbench/aics_host_model.sv
// host stand-in: register port, start input and analog raw code
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
`default_nettype none
module aics_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] rd_data_i,
  output logic      [7:0]  addr_o,
  output logic      [31:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic             start_n_o,
  output logic      [11:0] raw_o
);
  // idle levels from time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    start_n_o = 1'b1;
    raw_o = 12'h000;
  end

  // one-cycle write; bus shows inverted junk once released
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1 d = rd_data_i;
  endtask

  // start pulse; raw code held until the next start
  task automatic start(input logic [11:0] r);
    @(posedge clk_i);
    raw_o <= r;
    start_n_o <= 1'b0;
    @(posedge clk_i);
    start_n_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the input-config block
// assumes the host model drives every bus and start input
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("BAD %s exp %h got %h", nm, e, g); \
  end \
end
module testbench;
  import aics_pkg::*;
  localparam int CC = 8; // short conversion keeps the run brief
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d, r;
  logic        wr, rd, sn, span, busy, manual, valid, m;
  logic [11:0] raw, result;
  aics_mux_t   mux;
  aics_ctrl_t  c, n;
  logic [31:0] seed = 32'hf0617a04;
  int          failures = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          k;

  always #2 ref_clk_i = ~ref_clk_i;

  aics_host_model aics_host_model_inst (
    .clk_i(ref_clk_i), .rd_data_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .start_n_o(sn),
    .raw_o(raw));

  aics_top #(.CONV_CYC(CC)) aics_top_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .addr_i(addr), .wr_data_i(wdata), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rdata), .sample_start_n_i(sn), .raw_code_i(raw),
    .mux_sel_o(mux), .span_double_o(span), .busy_o(busy),
    .manual_o(manual), .result_o(result), .result_valid_o(valid));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected multiplexer setting per arrangement
  function automatic aics_mux_t mexp(aics_ctrl_t x);
    mexp = '0;
    mexp.pos = x.chan_pick_field;
    case ({x.input_config_hi, x.input_config_lo})
      CFG_SINGLE: begin
        mexp.neg = x.chan_pick_field; // unused side left on the pick
        mexp.neg_gnd = 1'b1;
      end
      CFG_DIFF: begin
        mexp.neg = x.chan_pick_field ^ 3'h1;
        mexp.fully_diff = 1'b1;
      end
      CFG_PSEUDO4: mexp.neg = x.chan_pick_field ^ 3'h1;
      default: mexp.neg = COMMON_REF;
    endcase
  endfunction

  function automatic logic [11:0] cexp(logic [11:0] v, logic t);
    return t ? {~v[11], v[10:0]} : v;
  endfunction

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard well above the expected run length
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    aics_host_model_inst.rd(OFS_CTRL, d);
    `CHK("ctrl rst", 32'h0, d)
    `CHK("mux rst", mexp(9'h000), mux)
    `CHK("manual rst", 1'b1, manual)
    // every arrangement, random channel, span, coding, scan bits
    for (int i = 0; i < 16; i++) begin
      r = xs();
      c = aics_ctrl_t'(r[8:0]);
      {c.input_config_hi, c.input_config_lo} = i[1:0];
      if (i < 4)
        {c.autoscan_ctrl_b, c.autoscan_ctrl_a} = 2'h0;
      if (i == 3)
        c.chan_pick_field = 3'h6;
      m = ~(c.autoscan_ctrl_a | c.autoscan_ctrl_b);
      aics_host_model_inst.wr(OFS_CTRL, {23'h0, c});
      @(posedge ref_clk_i);
      #1;
      `CHK("mux", mexp(c), mux)
      `CHK("span", c.span_double, span)
      `CHK("manual", m, manual)
      r = xs();
      // both span ends on a differential pair
      if (i == 2)
        r[27:16] = 12'hfff;
      if (i == 6)
        r[27:16] = 12'h000;
      aics_host_model_inst.start(r[27:16]);
      aics_host_model_inst.rd(OFS_STATUS, d);
      `CHK("status", {19'h0, c, 2'h0, m, 1'b1}, d)
      // rewrite mid-conversion, then a start that must be ignored
      d = xs();
      n = aics_ctrl_t'(d[8:0]);
      aics_host_model_inst.wr(OFS_CTRL, {23'h0, n});
      @(posedge ref_clk_i);
      #1;
      `CHK("mux held", mexp(c), mux)
      `CHK("busy", 1'b1, busy)
      aics_host_model_inst.start(r[27:16]);
      k = 0;
      while (valid !== 1'b1 && k < 40) begin
        @(posedge ref_clk_i);
        #1;
        k++;
      end
      `CHK("valid", 1'b1, valid)
      `CHK("result", cexp(r[27:16], c.fmt_twos), result)
      repeat (2) @(posedge ref_clk_i);
      #1;
      `CHK("no restart", 1'b0, busy)
      `CHK("mux next", mexp(n), mux)
      aics_host_model_inst.rd(OFS_RESULT, d);
      `CHK("result reg", {20'h0, cexp(r[27:16], c.fmt_twos)}, d)
    end
    // a write to the read-only status place leaves the channel alone; an unmapped place reads zero
    aics_host_model_inst.wr(OFS_STATUS, 32'hffffffff);
    aics_host_model_inst.rd(OFS_CTRL, d);
    `CHK("ctrl kept", {23'h0, n}, d)
    aics_host_model_inst.rd(8'h0c, d);
    `CHK("unmapped", 32'h0, d)
    @(posedge ref_clk_i);
    #1;
    `CHK("rd drop", 32'h0, rdata)
    complete_run();
  end
endmodule
`default_nettype wire
